// ### common/mio_pkg.sv
// constants and types of the manual io mode signal interface
package mio_pkg;

    localparam int CLK_PERIOD_NS = 100;
    localparam int JOG_SLOW_NS = 400_000;
    localparam int JOG_FAST_NS = 40_000;
    localparam logic [15:0] SLOW_RST = 16'(JOG_SLOW_NS / CLK_PERIOD_NS);
    localparam logic [15:0] FAST_RST = 16'(JOG_FAST_NS / CLK_PERIOD_NS);

    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_POSITION = 8'h08;
    localparam logic [7:0] OFS_TARGET = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_LIST_INDEX = 8'h18;
    localparam logic [7:0] OFS_LIST_DATA = 8'h1c;
    localparam logic [7:0] OFS_SLOW = 8'h20;
    localparam logic [7:0] OFS_FAST = 8'h24;

    localparam logic [1:0] MODE_FIXED = 2'h2;
    localparam logic [1:0] MODE_RST = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERROR = 1;
    localparam int IRQ_TEACH = 2;
    localparam int IRQ_HOME = 3;
    localparam int LIST_N = 64;

    typedef enum logic [2:0] {
        MIO_IDLE = 3'b001,
        MIO_JOG = 3'b010,
        MIO_AUTO = 3'b100
    } mio_motion_type;

    typedef struct packed {
        logic [5:0] list_select_in;
        logic run_select_in;
        logic jog_positive_in;
        logic jog_negative_in;
        logic jog_speed_sel;
        logic limit_pos_n;
        logic limit_neg_n;
        logic stop_n;
        logic enable_in;
        logic error_clear_in;
        logic teach_trigger_in;
        logic home_ref_n;
    } mio_pins_in_type;

    typedef struct packed {
        logic run_select_confirm_out;
        logic motion_done_out;
        logic motion_error_out;
        logic motion_extra_status_out;
        logic operational_ready_out;
        logic motor_energised_out;
        logic step_out;
        logic direction_out;
    } mio_pins_out_type;

    typedef struct packed {
        logic [23:0] zero;
        logic direction;
        logic fixed;
        logic done;
        logic error;
        logic manual;
        mio_motion_type motion;
    } mio_status_type;

    typedef struct packed {
        mio_pins_out_type pins;
        mio_motion_type motion;
        logic [1:0] io_mode;
        logic [31:0] position;
        logic [31:0] target;
        logic [15:0] slow_period;
        logic [15:0] fast_period;
        logic [15:0] div;
        logic [5:0] list_index;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic error;
        logic teach_prev;
        logic home_prev;
        logic [LIST_N-1:0][31:0] list_mem;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mio_state_type;

endpackage

// ### tb/mio_checker.sv
// assertion checker for the signal interface ports
`timescale 1ns/1ps
module mio_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [mio_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [mio_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire mio_pkg::mio_pins_in_type pins_in,
    input wire mio_pkg::mio_pins_out_type pins_out,
    input wire logic irq_out
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    confirm_follow_a: assert property (
        pins_out.run_select_confirm_out |-> $past(pins_in.run_select_in))
        else $error("confirm without run select");
    energised_enable_a: assert property (
        pins_out.motor_energised_out |-> $past(pins_in.enable_in))
        else $error("energised without enable");
    step_not_done_a: assert property (
        pins_out.step_out |-> $past(!pins_out.motion_done_out))
        else $error("step while done");
    stop_halts_a: assert property (
        !pins_in.stop_n [*2] |=> !pins_out.step_out)
        else $error("step while stopped");
    limit_pos_block_a: assert property (
        !pins_in.limit_pos_n [*2] |=> !(pins_out.step_out && pins_out.direction_out))
        else $error("positive step past limit");
    limit_neg_block_a: assert property (
        !pins_in.limit_neg_n [*2] |=> !(pins_out.step_out && !pins_out.direction_out))
        else $error("negative step past limit");
    error_held_a: assert property (
        pins_out.motion_error_out && !pins_in.error_clear_in |=> pins_out.motion_error_out)
        else $error("fault dropped without clear");
    error_clear_a: assert property (
        pins_in.error_clear_in [*2] |=> !pins_out.motion_error_out)
        else $error("fault kept after clear");
    ready_no_error_a: assert property (
        pins_out.operational_ready_out |-> !pins_out.motion_error_out)
        else $error("ready with fault");
    extra_moving_a: assert property (
        pins_out.motion_extra_status_out |-> !pins_out.motion_done_out)
        else $error("extra status at standstill");
    bresp_stands_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    cover property (pins_out.step_out);
    cover property ($rose(pins_out.motion_error_out));
    cover property ($rose(irq_out));
endmodule

// ### tb/mio_far_side.sv
// switch bank, plc and brake amplifier beside the block
`timescale 1ns/1ps
module mio_far_side (
    input wire logic aclk,
    input wire mio_pkg::mio_pins_in_type sw,
    input wire mio_pkg::mio_pins_out_type pins_out,
    output mio_pkg::mio_pins_in_type pins_in,
    output logic brake_released,
    output logic [31:0] steps
);
    assign pins_in = sw;
    assign brake_released = pins_out.motor_energised_out;
    initial steps = 32'h0000_0000;
    // axis position from step pulses
    always @(posedge aclk) begin
        if (pins_out.step_out) begin
            steps <= pins_out.direction_out ? steps + 1 : steps - 1;
        end
    end
endmodule

// ### tb/tb_manual_io_mode_signal_interface.sv
// testbench of the signal interface
`timescale 1ns/1ps
module tb_manual_io_mode_signal_interface;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, irq_out, brake;
    logic [mio_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, steps, rv, p, s0, s1;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    mio_pkg::mio_pins_in_type sw, pins_in;
    mio_pkg::mio_pins_out_type pins_out;
    int n_fail = 0;
    int checked = 0;
    mio_signal_if dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins_in, .pins_out,
        .irq_out);
    mio_far_side far (.aclk, .sw, .pins_out, .pins_in, .brake_released(brake), .steps);
    task complete_run;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
    task t_reset;
        chk(pins_out.motion_done_out, 1'b1);
        chk(pins_out.operational_ready_out, 1'b1);
        rd(mio_pkg::OFS_MODE, rv);
        chk(rv, 32'h0000_0002);
        chk(resp, mio_pkg::RESP_OKAY);
        rd(8'h40, rv);
        chk(rv, 32'h0000_0000);
        chk(resp, mio_pkg::RESP_SLVERR);
        wr(8'h40, 32'h0000_0001);
        chk(resp, mio_pkg::RESP_SLVERR);
    endtask
    task t_jog;
        wr(mio_pkg::OFS_SLOW, 32'h0000_0004);
        wr(mio_pkg::OFS_FAST, 32'h0000_0002);
        sw.jog_positive_in <= 1'b1;
        tick(2);
        s0 = steps;
        tick(24);
        chk(pins_out.motion_done_out, 1'b0);
        chk(pins_out.direction_out, 1'b1);
        chk(pins_out.motion_extra_status_out, 1'b0);
        s1 = steps;
        sw.jog_speed_sel <= 1'b1;
        tick(24);
        chk(pins_out.motion_extra_status_out, 1'b1);
        chk(steps - s1 > s1 - s0, 1'b1);
        sw.jog_positive_in <= 1'b0;
        sw.jog_speed_sel <= 1'b0;
        sw.jog_negative_in <= 1'b1;
        tick(20);
        chk(pins_out.direction_out, 1'b0);
        sw.jog_negative_in <= 1'b0;
        tick(3);
        chk(pins_out.motion_done_out, 1'b1);
        rd(mio_pkg::OFS_POSITION, rv);
        chk(rv, steps);
    endtask
    task t_stop;
        sw.stop_n <= 1'b0;
        sw.jog_positive_in <= 1'b1;
        tick(2);
        s0 = steps;
        tick(16);
        chk(steps, s0);
        sw.stop_n <= 1'b1;
        sw.enable_in <= 1'b0;
        tick(2);
        s0 = steps;
        tick(16);
        chk(steps, s0);
        chk(brake, 1'b0);
        sw.enable_in <= 1'b1;
        tick(3);
        chk(brake, 1'b1);
        sw.jog_positive_in <= 1'b0;
        tick(3);
    endtask
    task t_limit;
        wr(mio_pkg::OFS_IRQ_MASK, 32'h0000_0002);
        sw.jog_positive_in <= 1'b1;
        tick(6);
        sw.limit_pos_n <= 1'b0;
        tick(3);
        chk(pins_out.motion_error_out, 1'b1);
        chk(pins_out.operational_ready_out, 1'b0);
        chk(irq_out, 1'b1);
        sw.jog_positive_in <= 1'b0;
        sw.limit_pos_n <= 1'b1;
        tick(4);
        chk(pins_out.motion_error_out, 1'b1);
        sw.error_clear_in <= 1'b1;
        tick(2);
        sw.error_clear_in <= 1'b0;
        tick(2);
        chk(pins_out.motion_error_out, 1'b0);
        rd(mio_pkg::OFS_IRQ_STATUS, rv);
        chk(rv[1:0], 2'b11);
        wr(mio_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
        tick(2);
        chk(irq_out, 1'b0);
    endtask
    task t_teach;
        sw.list_select_in <= 6'h25;
        tick(2);
        sw.teach_trigger_in <= 1'b1;
        tick(3);
        sw.teach_trigger_in <= 1'b0;
        rd(mio_pkg::OFS_POSITION, p);
        wr(mio_pkg::OFS_LIST_INDEX, 32'h0000_0025);
        rd(mio_pkg::OFS_LIST_DATA, rv);
        chk(rv, p);
        wr(mio_pkg::OFS_LIST_INDEX, 32'h0000_0029);
        rd(mio_pkg::OFS_LIST_DATA, rv);
        chk(rv, 32'h0000_0000);
    endtask
    task t_auto;
        sw.run_select_in <= 1'b1;
        tick(3);
        chk(pins_out.run_select_confirm_out, 1'b1);
        rd(mio_pkg::OFS_POSITION, p);
        wr(mio_pkg::OFS_TARGET, p + 32'h0000_0005);
        tick(2);
        chk(pins_out.motion_done_out, 1'b0);
        for (int i = 0; i < 100 && pins_out.motion_done_out !== 1'b1; i++) tick(1);
        rd(mio_pkg::OFS_POSITION, rv);
        chk(rv, p + 32'h0000_0005);
        sw.run_select_in <= 1'b0;
        tick(3);
        chk(pins_out.run_select_confirm_out, 1'b0);
    endtask
    task t_home;
        sw.home_ref_n <= 1'b0;
        tick(3);
        sw.home_ref_n <= 1'b1;
        rd(mio_pkg::OFS_POSITION, rv);
        chk(rv, 32'h0000_0000);
        wr(mio_pkg::OFS_TARGET, 32'h0000_0003);
        tick(2);
        chk(pins_out.motion_error_out, 1'b1);
        chk(pins_out.operational_ready_out, 1'b0);
        sw.error_clear_in <= 1'b1;
        tick(2);
        sw.error_clear_in <= 1'b0;
        tick(2);
        chk(pins_out.motion_error_out, 1'b0);
    endtask
    task t_mode;
        wr(mio_pkg::OFS_MODE, 32'h0000_0000);
        chk(resp, mio_pkg::RESP_OKAY);
        tick(2);
        // direction keeps the last positive move
        chk(pins_out, 32'h0000_0001);
        wr(mio_pkg::OFS_MODE, 32'h0000_0002);
        tick(2);
        chk(pins_out.operational_ready_out, 1'b1);
    endtask
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        #5_000_000;
        n_fail++;
        complete_run;
    end
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        sw = '0;
        sw.stop_n = 1'b1;
        sw.limit_pos_n = 1'b1;
        sw.limit_neg_n = 1'b1;
        sw.home_ref_n = 1'b1;
        sw.enable_in = 1'b1;
        tick(6);
        aresetn <= 1'b1;
        tick(2);
        t_reset;
        t_jog;
        t_stop;
        t_limit;
        t_teach;
        t_auto;
        t_home;
        t_mode;
        complete_run;
    end
endmodule
bind mio_signal_if mio_checker chk_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins_in, .pins_out,
    .irq_out);

// ### verilog/mio_signal_if.sv
// manual io mode signal interface with axi4-lite registers
//
// Notes on behaviour
// - io mode value 2 selects the fixed manual and field bus pin assignment.
// - run select low gives manual jog and teach, high gives field bus.
// - confirm output mirrors the run select input, high active.
// - six list select inputs form the list number, first input bit 0.
// - teach trigger stores the current position into the selected list entry.
// - in manual mode jog positive or negative while the jog input is high.
// - jog speed input low selects slow jog, high selects fast jog.
// - both limit switch inputs are active low and block travel that way.
// - enable high powers the amplifier, enable low disables it.
// - done output high when movement ended and the drive stands still.
// - error output high when a fault is found during a movement command.
// - extra status output gives more detail on the running movement.
// - ready output high while the device is operational.
// - motor energised output high while the motor carries current.
`timescale 1ns/1ps
module mio_signal_if (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [mio_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [mio_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire mio_pkg::mio_pins_in_type pins_in,
    output mio_pkg::mio_pins_out_type pins_out,
    output logic irq_out
);

    // registered state and its next copy
    mio_pkg::mio_state_type s;
    mio_pkg::mio_state_type n;
    logic fixed;
    logic manual;
    logic go_ok;
    logic jp;
    logic jn;
    logic fwd;
    logic tick;
    logic hit_limit;
    logic fault;
    logic [15:0] period;
    logic [mio_pkg::IRQ_W-1:0] ev;
    logic [mio_pkg::IRQ_W-1:0] w1c;
    logic [31:0] wm;
    mio_pkg::mio_status_type st;

    // address decode shared by read and write
    function automatic logic mapped(input logic [mio_pkg::ADDR_W-1:0] a);
        unique case (a)
            mio_pkg::OFS_MODE, mio_pkg::OFS_STATUS, mio_pkg::OFS_POSITION,
            mio_pkg::OFS_TARGET, mio_pkg::OFS_IRQ_STATUS, mio_pkg::OFS_IRQ_MASK,
            mio_pkg::OFS_LIST_INDEX, mio_pkg::OFS_LIST_DATA,
            mio_pkg::OFS_SLOW, mio_pkg::OFS_FAST: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // byte lane merge
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // travel limit reached in the given direction
    function automatic logic blocked(
        input logic dir_pos,
        input mio_pkg::mio_pins_in_type p
    );
        blocked = dir_pos ? !p.limit_pos_n : !p.limit_neg_n;
    endfunction

    // outputs straight from the state register
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign pins_out = s.pins;
    assign irq_out = s.irq;

    always_comb begin
        n = s;
        ev = '0;
        w1c = '0;
        wm = '0;
        fault = 1'b0;
        hit_limit = 1'b0;
        tick = 1'b0;
        fixed = s.io_mode == mio_pkg::MODE_FIXED;
        manual = fixed && !pins_in.run_select_in;
        go_ok = fixed && pins_in.enable_in && pins_in.stop_n;
        // both jog inputs at once mean no jog
        jp = pins_in.jog_positive_in && !pins_in.jog_negative_in;
        jn = pins_in.jog_negative_in && !pins_in.jog_positive_in;
        // step is a one cycle pulse
        n.pins.step_out = 1'b0;

        // speed choice, field bus moves run fast
        if (s.motion == mio_pkg::MIO_AUTO || pins_in.jog_speed_sel) begin
            period = s.fast_period;
        end else begin
            period = s.slow_period;
        end
        if (s.motion == mio_pkg::MIO_AUTO) begin
            fwd = $signed(s.target) > $signed(s.position);
        end else begin
            fwd = jp;
        end

        // motion sequencer
        unique case (s.motion)
            mio_pkg::MIO_IDLE: begin
                n.div = '0;
                if (go_ok && manual && (jp || jn) && !blocked(jp, pins_in)) begin
                    n.motion = mio_pkg::MIO_JOG;
                end
            end
            mio_pkg::MIO_JOG: begin
                if (!go_ok || !manual || !(jp || jn)) begin
                    n.motion = mio_pkg::MIO_IDLE;
                end
            end
            mio_pkg::MIO_AUTO: begin
                if (!go_ok || manual) begin
                    n.motion = mio_pkg::MIO_IDLE;
                end else if (s.position == s.target) begin
                    n.motion = mio_pkg::MIO_IDLE;
                end
            end
        endcase

        // step divider and limit guard of a running move
        if (s.motion != mio_pkg::MIO_IDLE && n.motion != mio_pkg::MIO_IDLE) begin
            if (blocked(fwd, pins_in)) begin
                hit_limit = 1'b1;
                n.motion = mio_pkg::MIO_IDLE;
            end else begin
                tick = (s.div + 16'h0001) >= period;
                n.div = tick ? 16'h0000 : s.div + 16'h0001;
                if (tick) begin
                    n.pins.step_out = 1'b1;
                    n.pins.direction_out = fwd;
                    n.position = fwd ? s.position + 32'h0000_0001
                                     : s.position - 32'h0000_0001;
                end
            end
        end
        // a limit reached in travel is a fault
        if (hit_limit) begin
            fault = 1'b1;
        end

        // home reference falling edge zeroes position
        n.home_prev = pins_in.home_ref_n;
        if (fixed && s.home_prev && !pins_in.home_ref_n) begin
            n.position = '0;
            ev[mio_pkg::IRQ_HOME] = 1'b1;
        end

        // teach in on rising trigger edge
        n.teach_prev = pins_in.teach_trigger_in;
        if (manual && pins_in.teach_trigger_in && !s.teach_prev) begin
            n.list_mem[pins_in.list_select_in] = s.position;
            ev[mio_pkg::IRQ_TEACH] = 1'b1;
        end

        // axi write address and data, either order
        if (s.awready && s_axi_awvalid) begin
            n.awready = 1'b0;
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid) begin
            n.wready = 1'b0;
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end

        // both halves in, answer and apply the write
        if (s.aw_got && s.w_got && !s.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = mapped(s.awaddr) ? mio_pkg::RESP_OKAY : mio_pkg::RESP_SLVERR;
            unique case (s.awaddr)
                mio_pkg::OFS_MODE: begin
                    wm = merge({30'h0, s.io_mode}, s.wdata, s.wstrb);
                    n.io_mode = wm[1:0];
                end
                mio_pkg::OFS_TARGET: begin
                    n.target = merge(s.target, s.wdata, s.wstrb);
                    if (go_ok && !manual) begin
                        n.motion = mio_pkg::MIO_AUTO;
                        n.div = '0;
                    end else begin
                        fault = 1'b1;
                    end
                end
                mio_pkg::OFS_IRQ_STATUS: begin
                    wm = merge(32'h0000_0000, s.wdata, s.wstrb);
                    w1c = wm[mio_pkg::IRQ_W-1:0];
                end
                mio_pkg::OFS_IRQ_MASK: begin
                    wm = merge({28'h0, s.irq_mask}, s.wdata, s.wstrb);
                    n.irq_mask = wm[mio_pkg::IRQ_W-1:0];
                end
                mio_pkg::OFS_LIST_INDEX: begin
                    wm = merge({26'h0, s.list_index}, s.wdata, s.wstrb);
                    n.list_index = wm[5:0];
                end
                mio_pkg::OFS_SLOW: begin
                    wm = merge({16'h0, s.slow_period}, s.wdata, s.wstrb);
                    n.slow_period = wm[15:0];
                end
                mio_pkg::OFS_FAST: begin
                    wm = merge({16'h0, s.fast_period}, s.wdata, s.wstrb);
                    n.fast_period = wm[15:0];
                end
                default: begin
                    // read only and unmapped words change nothing
                end
            endcase
        end

        // response taken, write slots open again
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end

        // fault latch, a new fault wins over the clear
        if (fault) begin
            n.error = 1'b1;
            ev[mio_pkg::IRQ_ERROR] = !s.error;
        end else if (pins_in.error_clear_in) begin
            n.error = 1'b0;
        end

        // outputs of the fixed assignment, low in other modes except direction_out, which keeps its last value
        n.pins.run_select_confirm_out = fixed && pins_in.run_select_in;
        n.pins.motor_energised_out = fixed && pins_in.enable_in;
        n.pins.motion_done_out = fixed && n.motion == mio_pkg::MIO_IDLE;
        n.pins.motion_error_out = fixed && n.error;
        n.pins.motion_extra_status_out = fixed && n.motion != mio_pkg::MIO_IDLE
            && (n.motion == mio_pkg::MIO_AUTO || pins_in.jog_speed_sel);
        n.pins.operational_ready_out = fixed && !n.error;
        if (n.pins.motion_done_out && !s.pins.motion_done_out) begin
            ev[mio_pkg::IRQ_DONE] = 1'b1;
        end

        // sticky events, set wins over write one to clear
        n.irq_status = (s.irq_status & ~w1c) | ev;
        n.irq = |(n.irq_status & n.irq_mask);

        // axi read
        st = '0;
        st.motion = s.motion;
        st.manual = manual;
        st.error = s.error;
        st.done = s.pins.motion_done_out;
        st.fixed = fixed;
        st.direction = s.pins.direction_out;

        // read address taken, data registered for the next cycle
        if (s.arready && s_axi_arvalid) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = mapped(s_axi_araddr) ? mio_pkg::RESP_OKAY : mio_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
                mio_pkg::OFS_MODE: n.rdata = {30'h0, s.io_mode};
                mio_pkg::OFS_STATUS: n.rdata = st;
                mio_pkg::OFS_POSITION: n.rdata = s.position;
                mio_pkg::OFS_TARGET: n.rdata = s.target;
                mio_pkg::OFS_IRQ_STATUS: n.rdata = {28'h0, s.irq_status};
                mio_pkg::OFS_IRQ_MASK: n.rdata = {28'h0, s.irq_mask};
                mio_pkg::OFS_LIST_INDEX: n.rdata = {26'h0, s.list_index};
                mio_pkg::OFS_LIST_DATA: n.rdata = s.list_mem[s.list_index];
                mio_pkg::OFS_SLOW: n.rdata = {16'h0, s.slow_period};
                mio_pkg::OFS_FAST: n.rdata = {16'h0, s.fast_period};
                default: n.rdata = 32'h0000_0000;
            endcase
        end

        // read data taken, address slot open again
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end
    end

    // state register, synchronous active low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.motion <= mio_pkg::MIO_IDLE;
            s.io_mode <= mio_pkg::MODE_RST;
            s.slow_period <= mio_pkg::SLOW_RST;
            s.fast_period <= mio_pkg::FAST_RST;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
            s.teach_prev <= 1'b1;
            s.home_prev <= 1'b0;
        end else begin
            s <= n;
        end
    end

endmodule
